// [lpps_sequencer.sv]
// lcd panel power sequencer with power-down pin states
// Function
// - panel_select_n low while lcd is main display, else high.
// - lcd mode bit one drives panel_select_n low, zero drives high.
// - crt mode keeps both enables high through power-down.
// - system power-down: data buses tristated, control pins driven high.
// - any power-down: all video pins low, pixel clock normal except in system power-down.
`timescale 1ns/10ps
`default_nettype none
module lpps_sequencer import lpps_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// motherboard pins
	input wire logic power_good,
	input wire logic sleep_request_n,
	input wire logic sleep_request_p,
	input wire logic board_reset,
	// display select register bit and power-down mode
	input wire logic lcd_mode,
	input wire lpps_pd_mode_t pd_mode,
	// frame strobe from the display timing
	input wire logic frame_pulse,
	// normal pin values from the core
	input wire lpps_host_pins_t host_core,
	input wire lpps_video_pins_t video_core,
	// panel power
	output logic panel_select_n,
	output logic panel_power_en_n,
	output logic backlight_en_n,
	// pins as driven
	output var lpps_host_pins_t host_pins,
	output var lpps_video_pins_t video_pins,
	output logic sleeping
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [4:0] sync_a;
	logic [4:0] sync_b;
	wire [4:0] raw_in = {power_good, sleep_request_n, sleep_request_p, board_reset, frame_pulse};

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			// idle levels, so no false sleep or strobe follows reset
			sync_a <= SYNC_IDLE;
			sync_b <= SYNC_IDLE;
		end else begin
			sync_a <= raw_in;
			sync_b <= sync_a;
		end
	end

	wire pg_s = sync_b[4];
	wire sleep_n_s = sync_b[3];
	wire sleep_p_s = sync_b[2];
	wire brst_s = sync_b[1];
	wire fp_s = sync_b[0];

	logic fp_d;
	always_ff @(posedge clk) begin
		if (sys_rst)
			fp_d <= SYNC_IDLE[0];
		else
			fp_d <= fp_s;
	end
	wire fp_rise = fp_s && !fp_d;

	// ----------------------------------------
	// panel select and sequencing
	// ----------------------------------------
	// either polarity of the sleep request enters power-down
	wire pd_active = !sleep_n_s || sleep_p_s;
	wire any_reset = sys_rst || brst_s;

	always_ff @(posedge clk) begin
		if (sys_rst)
			panel_select_n <= 1'b1;
		else
			panel_select_n <= !lcd_mode;
	end

	wire hold_off = panel_select_n || pd_active || any_reset || !pg_s;
	wire strobes_done;

	lpps_strobe_count #(.TARGET(FRAME_STROBES)) u_count (
		.clk(clk),
		.sys_rst(sys_rst),
		.clear(hold_off),
		.strobe(fp_rise),
		.done(strobes_done)
	);

	lpps_state_t state;
	lpps_state_t next_state;

	always_comb begin
		next_state = state;
		case (state)
			LPPS_OFF: begin
				if (!hold_off)
					next_state = LPPS_WAIT;
			end
			LPPS_WAIT: begin
				if (hold_off)
					next_state = LPPS_OFF;
				else if (strobes_done)
					next_state = LPPS_ON;
			end
			LPPS_ON: begin
				if (hold_off)
					next_state = LPPS_OFF;
			end
			default: next_state = LPPS_OFF;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			state <= LPPS_OFF;
		else
			state <= next_state;
	end

	// combinational so power loss and sleep act at once
	assign panel_power_en_n = hold_off || (state != LPPS_ON);
	assign backlight_en_n = hold_off;
	assign sleeping = pd_active;

	// ----------------------------------------
	// power-down pin states
	// ----------------------------------------
	wire sys_pd = pd_active && (pd_mode == LPPS_PD_SYSTEM);
	lpps_host_pins_t host_pd;
	lpps_video_pins_t video_pd;

	always_comb begin
		host_pd = host_core;
		host_pd.sys_data_oe = 1'b0;
		host_pd.mem_data_oe = 1'b0;
		host_pd.bus_ready = 1'b1;
		host_pd.irq = 1'b1;
		host_pd.wide_memory_select = 1'b1;
		host_pd.bios_rom_enable = 1'b1;
		host_pd.high_buffer_dir = 1'b1;
		host_pd.low_buffer_dir = 1'b1;
		host_pd.mem_oe_n = HOST_HIGH2;
		host_pd.mem_we_n = HOST_HIGH4;
		host_pd.mem_addr = HOST_HIGH9;
		host_pd.sys_data = HOST_HIGH16;
		host_pd.palette_read_strobe = 1'b1;
		host_pd.palette_write_strobe = 1'b1;
		video_pd = '0;
		if (!sys_pd)
			video_pd.pixel_clk = video_core.pixel_clk;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			host_pins <= '0;
			video_pins <= '0;
		end else begin
			host_pins <= sys_pd ? host_pd : host_core;
			video_pins <= pd_active ? video_pd : video_core;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_reset_holds_panel: assert property (@(posedge clk) sys_rst |-> ##1 panel_power_en_n)
		else $error("panel enabled right after reset");
	a_crt_keeps_off: assert property (@(posedge clk) disable iff (sys_rst)
		panel_select_n |-> panel_power_en_n && backlight_en_n)
		else $error("panel enabled in crt mode");
	a_pgood_drops_all: assert property (@(posedge clk) disable iff (sys_rst)
		!pg_s |-> panel_power_en_n && backlight_en_n)
		else $error("enable active without power good");
	a_sleep_drops_all: assert property (@(posedge clk) disable iff (sys_rst)
		pd_active |-> panel_power_en_n && backlight_en_n)
		else $error("enable active in power-down");
	a_panel_waits: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(panel_power_en_n) |-> $past(state) == LPPS_WAIT && $past(strobes_done))
		else $error("panel enabled without two strobes");
	a_backlight_prompt: assert property (@(posedge clk) disable iff (sys_rst)
		!panel_select_n && pg_s && !pd_active && !brst_s |-> !backlight_en_n)
		else $error("backlight delayed");
	a_select_follows: assert property (@(posedge clk) disable iff (sys_rst)
		lcd_mode |=> !panel_select_n)
		else $error("panel select not following mode bit");
	a_sys_pd_pins: assert property (@(posedge clk) disable iff (sys_rst)
		sys_pd |=> !host_pins.sys_data_oe && host_pins.bus_ready && host_pins.mem_we_n == HOST_HIGH4)
		else $error("host pins wrong in system power-down");
	a_pd_video_low: assert property (@(posedge clk) disable iff (sys_rst)
		pd_active |=> !video_pins.red && !video_pins.panel_shift_clk_x)
		else $error("video pins active in power-down");
	a_leave_pd_wait: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(pd_active) |-> panel_power_en_n [*3])
		else $error("panel enabled too soon after power-down");

	c_panel_on: cover property (@(posedge clk) disable iff (sys_rst) $fell(panel_power_en_n));
	c_sleep_entry: cover property (@(posedge clk) disable iff (sys_rst) state == LPPS_ON ##1 pd_active);
	c_power_loss: cover property (@(posedge clk) disable iff (sys_rst) state == LPPS_ON && !pg_s);
	c_crt_switch: cover property (@(posedge clk) disable iff (sys_rst) state == LPPS_ON ##1 panel_select_n);

endmodule : lpps_sequencer
`default_nettype wire

// [lpps_pkg.sv]
// package: types and constants of the lcd panel power sequencer
package lpps_pkg;

	localparam int FRAME_STROBES = 2;
	localparam int STROBE_CNT_W = 2;
	localparam logic [STROBE_CNT_W-1:0] STROBE_CNT_RST = 2'h0;
	// idle pin levels: power not good, awake, no board reset, strobe low
	localparam logic [4:0] SYNC_IDLE = 5'h08;

	// power-down modes
	typedef enum logic [1:0] {
		LPPS_PD_SYSTEM = 2'h0,
		LPPS_PD_IDLE = 2'h1,
		LPPS_PD_GEN_EXT = 2'h2,
		LPPS_PD_GEN_INT = 2'h3
	} lpps_pd_mode_t;

	// sequencer states, one-hot
	typedef enum logic [2:0] {
		LPPS_OFF = 3'h1,
		LPPS_WAIT = 3'h2,
		LPPS_ON = 3'h4
	} lpps_state_t;

	// host and memory pins in normal operation
	typedef struct packed {
		logic [15:0] sys_data;
		logic sys_data_oe;
		logic bus_ready;
		logic irq;
		logic wide_memory_select;
		logic bios_rom_enable;
		logic high_buffer_dir;
		logic low_buffer_dir;
		logic [1:0] mem_oe_n;
		logic [3:0] mem_we_n;
		logic [8:0] mem_addr;
		logic [15:0] mem_data;
		logic mem_data_oe;
		logic palette_read_strobe;
		logic palette_write_strobe;
	} lpps_host_pins_t;

	// panel and video pins
	typedef struct packed {
		logic [3:0] upper_data;
		logic [3:0] lower_data;
		logic frame_toggle;
		logic frame_pulse;
		logic line_pulse;
		logic panel_shift_clk_x;
		logic panel_weight_clk;
		logic pixel_clk;
		logic red;
		logic green;
		logic blue;
	} lpps_video_pins_t;

	localparam logic [15:0] HOST_HIGH16 = 16'hFFFF;
	localparam logic [8:0] HOST_HIGH9 = 9'h1FF;
	localparam logic [3:0] HOST_HIGH4 = 4'hF;
	localparam logic [1:0] HOST_HIGH2 = 2'h3;

endpackage : lpps_pkg

// [lpps_strobe_count.sv]
// frame strobe counter with clear
`timescale 1ns/10ps
`default_nettype none
module lpps_strobe_count import lpps_pkg::*; #(
	parameter int TARGET = FRAME_STROBES
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// control
	input wire logic clear,
	input wire logic strobe,
	// status
	output logic done
);

	// target must fit the counter
	if (TARGET < 1 || TARGET > (2 ** STROBE_CNT_W) - 1) begin : g_bad_target
		$error("lpps_strobe_count: TARGET out of range");
	end

	logic [STROBE_CNT_W-1:0] count;
	localparam logic [STROBE_CNT_W-1:0] TGT = STROBE_CNT_W'(TARGET);
	wire at_target = (count == TGT);
	wire [STROBE_CNT_W-1:0] next_count = clear ? STROBE_CNT_RST :
		(strobe && !at_target) ? count + 2'h1 : count;

	always_ff @(posedge clk) begin
		if (sys_rst)
			count <= STROBE_CNT_RST;
		else
			count <= next_count;
	end

	assign done = at_target && !clear;

endmodule : lpps_strobe_count
`default_nettype wire

// [lpps_panel_model.sv]
// model of the panel drivers and backlight supply
`timescale 1ns/10ps
`default_nettype none
module lpps_panel_model (
	// supply control from the bench
	input wire logic supply_on,
	// enables from the sequencer
	input wire logic panel_power_en_n,
	input wire logic backlight_en_n,
	// supply status and loads
	output logic power_good,
	output logic panel_on,
	output logic light_on
);
	// -----------
	// supply
	// -----------
	// good only while the supply is on
	assign power_good = supply_on;
	assign panel_on = supply_on & ~panel_power_en_n;
	assign light_on = supply_on & ~backlight_en_n;
endmodule : lpps_panel_model
`default_nettype wire

// [lpps_tb.sv]
// bench of the lcd panel power sequencer
`timescale 1ns/10ps
`default_nettype none
module tb import lpps_pkg::*;;
	logic clk, sys_rst, supply_on, power_good, sleep_request_n, sleep_request_p, board_reset;
	logic lcd_mode, frame_pulse, panel_select_n, panel_power_en_n, backlight_en_n, sleeping;
	logic panel_on, light_on;
	lpps_pd_mode_t pd_mode;
	lpps_host_pins_t host_core, host_pins;
	lpps_video_pins_t video_core, video_pins;
	int failures, total_checks;

	lpps_sequencer DUT (.clk, .sys_rst, .power_good, .sleep_request_n, .sleep_request_p,
		.board_reset, .lcd_mode, .pd_mode, .frame_pulse, .host_core, .video_core,
		.panel_select_n, .panel_power_en_n, .backlight_en_n, .host_pins, .video_pins,
		.sleeping);
	lpps_panel_model model (.supply_on, .panel_power_en_n, .backlight_en_n, .power_good,
		.panel_on, .light_on);

	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end

	// -----------
	// tasks
	// -----------
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk

	// one frame strobe, long enough to pass the synchroniser
	task automatic strobe();
		frame_pulse = 1;
		step(4);
		frame_pulse = 0;
		step(4);
	endtask : strobe

	task automatic print_verdict();
		if (failures == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : print_verdict

	task automatic reset_hold();
		step(10);
		chk("pe", 1, panel_power_en_n);
		chk("sel", 1, panel_select_n);
		sys_rst = 0;
	endtask : reset_hold

	task automatic lcd_on();
		lcd_mode = 1;
		step(1);
		chk("sel", 0, panel_select_n);
		step(3);
		chk("be", 0, backlight_en_n);
		chk("pe", 1, panel_power_en_n);
		strobe();
		chk("pe", 1, panel_power_en_n);
		strobe();
		chk("pe", 0, panel_power_en_n);
		chk("panel", 1, panel_on);
		chk("light", 1, light_on);
	endtask : lcd_on

	task automatic sleep_modes();
		for (int m = 0; m < 4; m++) begin
			pd_mode = lpps_pd_mode_t'(m);
			sleep_request_n = 0;
			sleep_request_p = 1;
			step(4);
			chk("pe", 1, panel_power_en_n);
			chk("be", 1, backlight_en_n);
			chk("sleeping", 1, sleeping);
			chk("sel", 0, panel_select_n);
			chk("video", 64'(m != 0) << 3, 64'(video_pins));
			if (m == 0) chk("host", 25'h0FFFFFB, {host_pins[40:19], host_pins[2:0]});
			else chk("host", 64'(host_core), 64'(host_pins));
			sleep_request_n = 1;
			sleep_request_p = 0;
			step(4);
			chk("pe", 1, panel_power_en_n);
			chk("sleeping", 0, sleeping);
			chk("video", 64'(video_core), 64'(video_pins));
			chk("host", 64'(host_core), 64'(host_pins));
			strobe();
			chk("pe", 1, panel_power_en_n);
			strobe();
			chk("pe", 0, panel_power_en_n);
		end
	endtask : sleep_modes

	// supply loss, then board reset; strobes seen meanwhile are dropped
	task automatic hold_offs();
		for (int k = 0; k < 2; k++) begin
			if (k == 0) supply_on = 0;
			else board_reset = 1;
			step(4);
			chk("pe", 1, panel_power_en_n);
			if (k == 0) chk("be", 1, backlight_en_n);
			strobe();
			supply_on = 1;
			board_reset = 0;
			step(4);
			strobe();
			chk("pe", 1, panel_power_en_n);
			strobe();
			chk("pe", 0, panel_power_en_n);
		end
	endtask : hold_offs

	task automatic crt_mode();
		lcd_mode = 0;
		step(1);
		chk("sel", 1, panel_select_n);
		step(3);
		chk("be", 1, backlight_en_n);
		strobe();
		strobe();
		chk("pe", 1, panel_power_en_n);
		sleep_request_n = 0;
		step(4);
		chk("pe", 1, panel_power_en_n);
		chk("be", 1, backlight_en_n);
		chk("sel", 1, panel_select_n);
		sleep_request_n = 1;
		step(4);
		strobe();
		strobe();
		chk("pe", 1, panel_power_en_n);
		chk("be", 1, backlight_en_n);
	endtask : crt_mode

	// -----------
	// sequence
	// -----------
	initial begin
		sys_rst = 1;
		supply_on = 1;
		sleep_request_n = 1;
		sleep_request_p = 0;
		board_reset = 0;
		lcd_mode = 0;
		frame_pulse = 0;
		pd_mode = LPPS_PD_SYSTEM;
		host_core = '0;
		video_core = '1;
		reset_hold();
		lcd_on();
		sleep_modes();
		hold_offs();
		crt_mode();
		print_verdict();
	end

	initial begin
		#(20 * 5000);
		failures++;
		print_verdict();
	end
endmodule : tb
`default_nettype wire
